//--- verilog/spw_rx_dma_regs.vh
/*
 * Register offsets, field positions, reset values and codes of the
 * receive DMA engine.
 * Assumes a 32-bit APB slave port and an AHB-lite master; no timing counts.
 */
//
// Function
// - Bytes past the maximum length are dropped; cut_short_flag set in word 0 bit 31.
// - Word 0 bit 28 set on error end, cleared on normal end.
// - desc_irq_enable with rx_irq_enable gives an interrupt when the packet is received.
// - Without wrap, index steps 0x8 and wraps at 1 KB; with wrap, back to base.
// - Bit 25 marks the buffer valid; length only meaningful after device clears it.
// - Word 1 bits 31-2 hold the buffer pointer; bits 1-0 are zero.
// - While rx_on is clear DMA-bound packets are discarded; RMAP commands still go to the handler.
// - Clearing rx_on mid-packet finishes that packet; later ones are discarded.
// - Descriptors-available clear: discard if no_spill_hold is 0, else hold and wait.
// - A fetched invalid descriptor clears descriptors-available, then spill or hold.
// - Software clearing descriptors-available spares the current packet; no more fetches.
// - First character compared with node address; mismatch discards through the end marker.
// - Accepted packets stored whole, address and protocol id included, markers excluded.
// - With RMAP on, protocol 0x01 and command 01b go to the RMAP handler.
// - Fewer than 2 data characters discarded; 3 when hardware RMAP decides routing.
// - On completion clear valid bit, set packet_received_flag, interrupt if enabled.
// - RMAP packets report header CRC error; data CRC only when header CRC is good.
// - Bus error spills the packet, disables the channel, idles, shows link_halt.
// - Open packet mode stores every data character, ignoring address; still truncates.
// - In open mode RMAP commands go to the handler only when RMAP is enabled.
// - Packet data written with full word accesses, last word overwritten whole.
`ifndef SPW_RX_DMA_REGS_VH
`define SPW_RX_DMA_REGS_VH

// APB register byte offsets
`define OFS_CTRL       8'h00
`define OFS_MAXLEN     8'h04
`define OFS_NODEADDR   8'h08
`define OFS_DESCTAB    8'h0c

// Control and status register bits
`define CB_RX_ON       0
`define CB_DESC_AVAIL  1
`define CB_NO_SPILL    2
`define CB_RX_IRQ_EN   3
`define CB_RMAP_EN     4
`define CB_OPEN_PKT    5
`define CB_LINK_HALT   6
`define CB_PKT_RCVD    8
`define CB_RX_ACTIVE   9

// Reset values
`define NODEADDR_RST   8'hfe
`define MAXLEN_RST     25'h0000400

// Descriptor word 0 fields
`define DW0_CUT        31
`define DW0_DCRC       30
`define DW0_HCRC       29
`define DW0_EEP        28
`define DW0_IRQ_EN     27
`define DW0_WRAP       26
`define DW0_VALID      25
`define DESC_STEP      32'h00000008
`define DESC_W1_OFS    32'h00000004

// Packet recognition
`define RMAP_PID       8'h01
`define RMAP_CMD       2'b01

// Link state codes shown to the link controller
`define LINK_RUN       3'h5
`define LINK_ERR_RESET 3'h0

// AHB encodings
`define HTRANS_IDLE    2'b00
`define HTRANS_NONSEQ  2'b10
`define HSIZE_WORD     3'b010
`define HBURST_SINGLE  3'b000

`endif

//--- verilog/spw_rx_dma.v
/*
 * Receive DMA engine: takes N-Chars from the receive FIFO, filters and
 * routes packets, fetches descriptors and stores packets over AHB.
 * Assumes the FIFO and the RMAP handler sit on the same clock, and that
 * a CRC checker alongside the FIFO gives header and data CRC results.
 */
`timescale 1ns/1ns
`include "spw_rx_dma_regs.vh"

module spw_rx_dma (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Receive N-Char FIFO
  input  wire        nc_valid,
  input  wire [7:0]  nc_data,
  input  wire        nc_eop,
  input  wire        nc_eep,
  output reg         nc_ready,
  // CRC checker results for the packet in progress
  input  wire        hdr_crc_bad,
  input  wire        dat_crc_bad,
  // RMAP command handler
  output reg         rmap_valid,
  output reg  [7:0]  rmap_data,
  output reg         rmap_end,
  input  wire        rmap_ready,
  // AHB-lite master
  output reg  [31:0] haddr,
  output reg  [1:0]  htrans,
  output reg         hwrite,
  output reg  [2:0]  hsize,
  output reg  [2:0]  hburst,
  output reg  [31:0] hwdata,
  input  wire [31:0] hrdata,
  input  wire        hready,
  input  wire        hresp,
  // Events and link indications
  output reg         rx_irq,
  output reg         link_halt,
  output reg  [2:0]  link_state_code
);

////////////////////////////////////////////////////////////////////////
localparam [3:0] S_IDLE  = 4'h0;
localparam [3:0] S_HDR1  = 4'h1;
localparam [3:0] S_HDR2  = 4'h2;
localparam [3:0] S_DEC   = 4'h3;
localparam [3:0] S_FD0   = 4'h4;
localparam [3:0] S_FD1   = 4'h5;
localparam [3:0] S_STORE = 4'h6;
localparam [3:0] S_WDAT  = 4'h7;
localparam [3:0] S_WSTAT = 4'h8;
localparam [3:0] S_SPILL = 4'h9;
localparam [3:0] S_RMAP  = 4'ha;

// Control state
reg        rx_on_r;
reg        desc_avail_r;
reg        no_spill_hold_r;
reg        rx_irq_enable_r;
reg        rmap_en_r;
reg        open_packet_select_r;
reg        packet_received_flag_r;
reg [24:0] maxlen_r;
reg [7:0]  node_addr_r;
reg [21:0] tab_base_r;
reg [6:0]  sel_r;

// Packet state
reg [3:0]  st_r;
reg [7:0]  hb [0:2];
reg [1:0]  hn_r;
reg [1:0]  hr_r;
reg        ended_r;
reg        is_rmap_r;
reg        cut_short_flag_r;
reg        error_end_flag_r;
reg        desc_irq_enable_r;
reg        wrap_r;
reg [24:0] len_r;
reg [31:0] waddr_r;
reg [31:0] wbuf_r;
reg [1:0]  bcnt_r;
reg        last_r;

// Bus engine
reg [1:0]  bph_r;
reg        bdone_r;
reg        berr_r;
reg [31:0] brdata_r;

wire       take = nc_valid & nc_ready;
wire       mark = nc_eop | nc_eep;
wire       apb_wr = psel & penable & pready & pwrite;
reg        want_c;
reg        issue_c;
reg [31:0] iaddr_c;
reg        iwr_c;
reg [31:0] iwdata_c;

// Descriptor word address inside the 1 KB table
function [31:0] dsc_addr;
  input [21:0] base;
  input [6:0]  sel;
  input        word1;
  begin
    dsc_addr = {base, sel, word1, 2'b00};
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Header bytes are replayed before the FIFO is read again
always @* begin
  want_c = 1'b0;
  case (st_r)
    S_IDLE, S_HDR1, S_HDR2, S_SPILL: want_c = 1'b1;
    S_STORE: want_c = (hr_r >= hn_r) & ~ended_r;
    S_RMAP:  want_c = (hr_r >= hn_r) & ~rmap_valid;
    default: want_c = 1'b0;
  endcase
end

// One bus access per access state; words only, never a byte lane
always @* begin
  issue_c  = 1'b0;
  iaddr_c  = 32'h00000000;
  iwr_c    = 1'b0;
  iwdata_c = 32'h00000000;
  if (bph_r == 2'd0 && !bdone_r) begin
    case (st_r)
      S_FD0: begin
        issue_c = 1'b1;
        iaddr_c = dsc_addr(tab_base_r, sel_r, 1'b0);
      end
      S_FD1: begin
        issue_c = 1'b1;
        iaddr_c = dsc_addr(tab_base_r, sel_r, 1'b1);
      end
      S_WDAT: begin
        issue_c  = 1'b1;
        iaddr_c  = waddr_r;
        iwr_c    = 1'b1;
        iwdata_c = wbuf_r;
      end
      S_WSTAT: begin
        issue_c  = 1'b1;
        iaddr_c  = dsc_addr(tab_base_r, sel_r, 1'b0);
        iwr_c    = 1'b1;
        iwdata_c = {cut_short_flag_r, is_rmap_r & dat_crc_bad & ~hdr_crc_bad,
                    is_rmap_r & hdr_crc_bad, error_end_flag_r, desc_irq_enable_r,
                    wrap_r, 1'b0, len_r};
      end
      default: issue_c = 1'b0;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// AHB-lite single transfers
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    haddr    <= 32'h00000000;
    htrans   <= `HTRANS_IDLE;
    hwrite   <= 1'b0;
    hsize    <= `HSIZE_WORD;
    hburst   <= `HBURST_SINGLE;
    hwdata   <= 32'h00000000;
    bph_r    <= 2'd0;
    bdone_r  <= 1'b0;
    berr_r   <= 1'b0;
    brdata_r <= 32'h00000000;
  end else begin
    bdone_r <= 1'b0;
    if (issue_c) begin
      haddr  <= iaddr_c;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= iwr_c;
      hwdata <= iwdata_c;
      bph_r  <= 2'd1;
    end else if (bph_r == 2'd1 && hready) begin
      htrans <= `HTRANS_IDLE;
      bph_r  <= 2'd2;
    end else if (bph_r == 2'd2 && hready) begin
      bph_r    <= 2'd0;
      bdone_r  <= 1'b1;
      berr_r   <= hresp;
      brdata_r <= hrdata;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// APB slave with one wait state so every answer comes from a flop
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready  <= 1'b0;
    pslverr <= 1'b0;
    prdata  <= 32'h00000000;
  end else begin
    pready  <= psel & penable & ~pready;
    pslverr <= 1'b0;
    if (psel && penable && !pready) begin
      prdata <= 32'h00000000;
      case (paddr[7:0])
        `OFS_CTRL: begin
          prdata[`CB_RX_ON]      <= rx_on_r;
          prdata[`CB_DESC_AVAIL] <= desc_avail_r;
          prdata[`CB_NO_SPILL]   <= no_spill_hold_r;
          prdata[`CB_RX_IRQ_EN]  <= rx_irq_enable_r;
          prdata[`CB_RMAP_EN]    <= rmap_en_r;
          prdata[`CB_OPEN_PKT]   <= open_packet_select_r;
          prdata[`CB_LINK_HALT]  <= link_halt;
          prdata[`CB_PKT_RCVD]   <= packet_received_flag_r;
          prdata[`CB_RX_ACTIVE]  <= (st_r != S_IDLE);
        end
        `OFS_MAXLEN:   prdata <= {7'h00, maxlen_r};
        `OFS_NODEADDR: prdata <= {24'h000000, node_addr_r};
        `OFS_DESCTAB:  prdata <= {tab_base_r, sel_r, 3'b000};
        default:       pslverr <= 1'b1;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Packet engine and control registers
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    rx_on_r                <= 1'b0;
    desc_avail_r           <= 1'b0;
    no_spill_hold_r        <= 1'b0;
    rx_irq_enable_r        <= 1'b0;
    rmap_en_r              <= 1'b0;
    open_packet_select_r   <= 1'b0;
    packet_received_flag_r <= 1'b0;
    maxlen_r               <= `MAXLEN_RST;
    node_addr_r            <= `NODEADDR_RST;
    tab_base_r             <= 22'h000000;
    sel_r                  <= 7'h00;
    link_halt              <= 1'b0;
    link_state_code        <= `LINK_RUN;
    st_r                   <= S_IDLE;
    hb[0]                  <= 8'h00;
    hb[1]                  <= 8'h00;
    hb[2]                  <= 8'h00;
    hn_r                   <= 2'd0;
    hr_r                   <= 2'd0;
    ended_r                <= 1'b0;
    is_rmap_r              <= 1'b0;
    cut_short_flag_r       <= 1'b0;
    error_end_flag_r       <= 1'b0;
    desc_irq_enable_r      <= 1'b0;
    wrap_r                 <= 1'b0;
    len_r                  <= 25'h0000000;
    waddr_r                <= 32'h00000000;
    wbuf_r                 <= 32'h00000000;
    bcnt_r                 <= 2'd0;
    last_r                 <= 1'b0;
    nc_ready               <= 1'b0;
    rmap_valid             <= 1'b0;
    rmap_data              <= 8'h00;
    rmap_end               <= 1'b0;
    rx_irq                 <= 1'b0;
  end else begin
    // Ready drops after each take so a state change never races it
    nc_ready <= want_c & ~take;
    rx_irq   <= 1'b0;
    if (rmap_valid && rmap_ready)
      rmap_valid <= 1'b0;
    // Software writes; hardware updates below win a same-cycle clash
    if (apb_wr) begin
      case (paddr[7:0])
        `OFS_CTRL: begin
          rx_on_r              <= pwdata[`CB_RX_ON];
          desc_avail_r         <= pwdata[`CB_DESC_AVAIL];
          no_spill_hold_r      <= pwdata[`CB_NO_SPILL];
          rx_irq_enable_r      <= pwdata[`CB_RX_IRQ_EN];
          rmap_en_r            <= pwdata[`CB_RMAP_EN];
          open_packet_select_r <= pwdata[`CB_OPEN_PKT];
          link_halt            <= pwdata[`CB_LINK_HALT];
          link_state_code      <= pwdata[`CB_LINK_HALT] ? `LINK_ERR_RESET : `LINK_RUN;
          if (pwdata[`CB_PKT_RCVD])
            packet_received_flag_r <= 1'b0;
        end
        `OFS_MAXLEN:   maxlen_r    <= pwdata[24:0];
        `OFS_NODEADDR: node_addr_r <= pwdata[7:0];
        `OFS_DESCTAB: begin
          tab_base_r <= pwdata[31:10];
          sel_r      <= pwdata[9:3];
        end
        default: ;
      endcase
    end
    case (st_r)
      S_IDLE: begin
        hn_r      <= 2'd0;
        hr_r      <= 2'd0;
        ended_r   <= 1'b0;
        is_rmap_r <= 1'b0;
        if (take && !mark) begin
          hb[0] <= nc_data;
          hn_r  <= 2'd1;
          if (!open_packet_select_r && nc_data != node_addr_r)
            st_r <= S_SPILL;
          else
            st_r <= S_HDR1;
        end
      end
      S_HDR1: begin
        if (take) begin
          if (mark) begin
            ended_r          <= 1'b1;
            error_end_flag_r <= nc_eep;
            st_r <= open_packet_select_r ? S_DEC : S_IDLE;
          end else begin
            hb[1]     <= nc_data;
            hn_r      <= 2'd2;
            is_rmap_r <= (nc_data == `RMAP_PID);
            if (rmap_en_r && nc_data == `RMAP_PID)
              st_r <= S_HDR2;
            else
              st_r <= S_DEC;
          end
        end
      end
      S_HDR2: begin
        if (take) begin
          if (mark) begin
            ended_r          <= 1'b1;
            error_end_flag_r <= nc_eep;
            st_r <= open_packet_select_r ? S_DEC : S_IDLE;
          end else begin
            hb[2] <= nc_data;
            hn_r  <= 2'd3;
            if (nc_data[7:6] == `RMAP_CMD)
              st_r <= S_RMAP;
            else
              st_r <= S_DEC;
          end
        end
      end
      S_DEC: begin
        // Enables are looked at once the header is in, and again every cycle while holding
        if (!rx_on_r)
          st_r <= ended_r ? S_IDLE : S_SPILL;
        else if (desc_avail_r)
          st_r <= S_FD0;
        else if (!no_spill_hold_r)
          st_r <= ended_r ? S_IDLE : S_SPILL;
      end
      S_FD0: begin
        if (bdone_r) begin
          if (berr_r) begin
            rx_on_r         <= 1'b0;
            link_halt       <= 1'b1;
            link_state_code <= `LINK_ERR_RESET;
            st_r            <= ended_r ? S_IDLE : S_SPILL;
          end else if (!brdata_r[`DW0_VALID]) begin
            desc_avail_r <= 1'b0;
            st_r         <= S_DEC;
          end else begin
            desc_irq_enable_r <= brdata_r[`DW0_IRQ_EN];
            wrap_r            <= brdata_r[`DW0_WRAP];
            st_r              <= S_FD1;
          end
        end
      end
      S_FD1: begin
        if (bdone_r) begin
          if (berr_r) begin
            rx_on_r         <= 1'b0;
            link_halt       <= 1'b1;
            link_state_code <= `LINK_ERR_RESET;
            st_r            <= ended_r ? S_IDLE : S_SPILL;
          end else begin
            waddr_r          <= {brdata_r[31:2], 2'b00};
            len_r            <= 25'h0000000;
            bcnt_r           <= 2'd0;
            cut_short_flag_r <= 1'b0;
            if (!ended_r)
              error_end_flag_r <= 1'b0;
            hr_r <= 2'd0;
            st_r <= S_STORE;
          end
        end
      end
      S_STORE: begin
        if (hr_r < hn_r || (take && !mark)) begin
          hr_r <= (hr_r < hn_r) ? hr_r + 2'd1 : hr_r;
          if (len_r < maxlen_r) begin
            wbuf_r[8*(3-bcnt_r) +: 8] <= (hr_r < hn_r) ? hb[hr_r] : nc_data;
            len_r  <= len_r + 25'd1;
            bcnt_r <= bcnt_r + 2'd1;
            if (bcnt_r == 2'd3) begin
              last_r <= 1'b0;
              st_r   <= S_WDAT;
            end
          end else begin
            cut_short_flag_r <= 1'b1;
          end
        end else if (take) begin
          ended_r          <= 1'b1;
          error_end_flag_r <= nc_eep;
        end else if (ended_r) begin
          // Partial final word is still written as a full word
          last_r <= 1'b1;
          st_r   <= (bcnt_r != 2'd0) ? S_WDAT : S_WSTAT;
        end
      end
      S_WDAT: begin
        if (bdone_r) begin
          if (berr_r) begin
            rx_on_r         <= 1'b0;
            link_halt       <= 1'b1;
            link_state_code <= `LINK_ERR_RESET;
            st_r            <= ended_r ? S_IDLE : S_SPILL;
          end else begin
            waddr_r <= waddr_r + 32'd4;
            bcnt_r  <= 2'd0;
            st_r    <= last_r ? S_WSTAT : S_STORE;
          end
        end
      end
      S_WSTAT: begin
        if (bdone_r) begin
          if (berr_r) begin
            rx_on_r         <= 1'b0;
            link_halt       <= 1'b1;
            link_state_code <= `LINK_ERR_RESET;
          end else begin
            sel_r <= wrap_r ? 7'h00 : sel_r + 7'h01;
            packet_received_flag_r <= 1'b1;
            rx_irq <= desc_irq_enable_r & rx_irq_enable_r;
          end
          st_r <= S_IDLE;
        end
      end
      S_SPILL: begin
        if (take && mark)
          st_r <= S_IDLE;
      end
      S_RMAP: begin
        if (!rmap_valid && hr_r < hn_r) begin
          rmap_valid <= 1'b1;
          rmap_data  <= hb[hr_r];
          rmap_end   <= 1'b0;
          hr_r       <= hr_r + 2'd1;
        end else if (take) begin
          rmap_valid <= 1'b1;
          rmap_data  <= nc_data;
          rmap_end   <= mark;
          if (mark)
            st_r <= S_IDLE;
        end
      end
      default: st_r <= S_IDLE;
    endcase
  end
end

endmodule

//--- tb/spw_rx_dma_asserts.sv
/* Port checker of the receive DMA engine.
   Assumes it is bound onto every spw_rx_dma instance. */
`timescale 1ns/1ns
module spw_rx_dma_asserts (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Observed ports
  input wire        pready,
  input wire        nc_valid,
  input wire        nc_ready,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire [2:0]  hsize,
  input wire [2:0]  hburst,
  input wire        hready,
  input wire        hresp,
  input wire        rx_irq,
  input wire        link_halt,
  input wire [2:0]  link_state_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  apb_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  char_gap_a: assert property (nc_valid && nc_ready |=> !nc_ready)
    else $error("nc_ready not dropped");
  word_size_a: assert property (hsize == 3'b010 && hburst == 3'b000)
    else $error("bus access not single word");
  word_align_a: assert property (htrans[1] |-> haddr[1:0] == 2'b00)
    else $error("unaligned bus address");
  addr_hold_a: assert property (htrans[1] && !hready |=> htrans[1] && $stable(haddr))
    else $error("address dropped in wait");
  err_halt_a: assert property (hresp && hready |-> ##[1:4] link_halt)
    else $error("bus error without halt");
  halt_state_a: assert property ($rose(link_halt) |-> ##[0:1] link_state_code == 3'h0)
    else $error("halt not shown in link state");
  irq_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("irq longer than a pulse");
  ////////////////////////////////////////
  cover property (rx_irq);
  cover property (hresp && hready);
  cover property (htrans[1] && !hready);
endmodule
bind spw_rx_dma spw_rx_dma_asserts i_spw_rx_dma_asserts (.pclk, .presetn, .pready,
  .nc_valid, .nc_ready, .haddr, .htrans, .hsize, .hburst, .hready, .hresp, .rx_irq,
  .link_halt, .link_state_code);

//--- tb/ahb_mem_model.sv
/* Word memory on AHB-lite with optional wait states and one error address.
   Assumes single transfers and 4 KB of decoded space. */
`timescale 1ns/1ns
module ahb_mem_model (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-lite slave
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hready,
  output wire        hresp,
  // Test controls
  input  wire        slow,
  input  wire [31:0] err_addr
);
  reg [31:0] mem [0:1023];
  reg        ph_r;
  reg        pw_r;
  reg [31:0] pa_r;
  reg [1:0]  wc_r;
  reg [31:0] junk_r;
  assign hready = !ph_r || wc_r == 2'd0;
  assign hresp  = ph_r && hready && pa_r == err_addr;
  // Outside a read data phase the bus shows a moving pattern, never a stale word
  assign hrdata = (ph_r && !pw_r && hready) ? mem[pa_r[11:2]] : junk_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 1'b0;
      wc_r <= 2'd0;
      junk_r <= 32'h5a5a5a5a;
    end else begin
      junk_r <= ~junk_r + 32'h1;
      if (hready) begin
        if (ph_r && pw_r && pa_r != err_addr) mem[pa_r[11:2]] <= hwdata;
        ph_r <= htrans[1];
        pw_r <= hwrite;
        pa_r <= haddr;
        wc_r <= slow ? 2'd2 : 2'd0;
      end else
        wc_r <= wc_r - 2'd1;
    end
  end
endmodule

//--- tb/test_spw_rx_dma.sv
/* Bench of the receive DMA engine: packets in, memory and control out.
   Assumes ahb_mem_model as system memory and the bound port checker. */
`timescale 1ns/1ns
`include "spw_rx_dma_regs.vh"
module test_spw_rx_dma;
  reg         pclk, presetn, psel, penable, pwrite, nc_valid, nc_eop, nc_eep;
  reg         hdr_crc_bad, dat_crc_bad, rmap_ready, slow, er;
  reg  [7:0]  nc_data;
  reg  [31:0] paddr, pwdata, err_addr, rd, w0, w1;
  wire [31:0] prdata, haddr, hwdata, hrdata;
  wire        pready, pslverr, nc_ready, rmap_valid, rmap_end, hwrite, hready, hresp;
  wire        rx_irq, link_halt;
  wire [7:0]  rmap_data;
  wire [1:0]  htrans;
  wire [2:0]  hsize, hburst, link_state_code;
  integer     fails, total_checks, irqs, exp_irqs, sel, k, ctl;
  reg  [7:0]  pq[$];
  reg  [7:0]  rq[$];
  spw_rx_dma i_spw_rx_dma (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nc_valid, .nc_data, .nc_eop, .nc_eep, .nc_ready,
    .hdr_crc_bad, .dat_crc_bad, .rmap_valid, .rmap_data, .rmap_end, .rmap_ready,
    .haddr, .htrans, .hwrite, .hsize, .hburst, .hwdata, .hrdata, .hready, .hresp,
    .rx_irq, .link_halt, .link_state_code);
  ahb_mem_model i_ahb_mem_model (.hclk(pclk), .hresetn(presetn), .haddr, .htrans,
    .hwrite, .hwdata, .hrdata, .hready, .hresp, .slow, .err_addr);
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    rmap_ready <= $urandom;
    if (rx_irq === 1'b1) irqs <= irqs + 1;
    if (rmap_valid && rmap_ready && !rmap_end) rq.push_back(rmap_data);
  end
  task check(input [32:0] seen, input [32:0] want);
    begin
      total_checks = total_checks + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, want);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task bound(input integer n, input integer lim);
    if (n >= lim) begin
      $display("mismatch at %0t: wait ran out", $time);
      fails = fails + 1;
      final_report;
    end
  endtask
  task apb(input w, input [31:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 20 && pready !== 1'b1; n = n + 1) @(posedge pclk);
      bound(n, 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task setc(input integer v);
    begin
      ctl = v;
      apb(1'b1, `OFS_CTRL, v);
    end
  endtask
  task put(input [7:0] b, input e, input x);
    integer n;
    begin
      nc_valid <= 1'b1;
      nc_data <= b;
      nc_eop <= e;
      nc_eep <= x;
      @(posedge pclk);
      for (n = 0; n < 3000 && nc_ready !== 1'b1; n = n + 1) @(posedge pclk);
      bound(n, 3000);
      nc_valid <= 1'b0;
      nc_eop <= 1'b0;
      nc_eep <= 1'b0;
      nc_data <= $urandom;
      @(posedge pclk);
    end
  endtask
  task sendp(input integer n, input [7:0] a0, input [7:0] b1, input [7:0] b2, input x);
    integer i;
    reg [7:0] r;
    begin
      pq = {};
      for (i = 0; i < n; i = i + 1) begin
        r = $urandom;
        pq.push_back(i == 0 ? a0 : i == 1 ? b1 : i == 2 ? b2 : r);
      end
      for (i = 0; i < n; i = i + 1) put(pq[i], 1'b0, 1'b0);
      put(r, !x, x);
    end
  endtask
  // Expected outcome is worked out after the last marker is taken
  task pkt(input integer n, input [7:0] a0, input [7:0] b1, input [7:0] b2,
           input x, input hb, input db);
    integer i, len, t;
    reg rm, st;
    begin
      hdr_crc_bad <= hb;
      dat_crc_bad <= db;
      w0 = i_ahb_mem_model.mem[256 + 2 * sel];
      w1 = i_ahb_mem_model.mem[257 + 2 * sel];
      rq = {};
      sendp(n, a0, b1, b2, x);
      rm = ctl[4] && b1 == 8'h01 && b2[7:6] == 2'b01 && (ctl[5] || a0 == 8'h22);
      st = !rm && ctl[0] && ctl[1] && w0[25] && (ctl[5] ? n > 0 : a0 == 8'h22 && n >= 2);
      for (t = 0; t < 400 && st && i_ahb_mem_model.mem[256 + 2 * sel][25]; t = t + 1)
        @(posedge pclk);
      bound(t, 400);
      if (!st) repeat (60) @(posedge pclk);
      len = n > 8 ? 8 : n;
      if (st) begin
        check(i_ahb_mem_model.mem[256 + 2 * sel], {n > 8, b1 == 8'h01 && !hb && db,
          b1 == 8'h01 && hb, x, w0[27:26], 1'b0, len[24:0]});
        for (i = 0; i < len; i = i + 1)
          check(i_ahb_mem_model.mem[w1[11:2] + i / 4] >> (24 - 8 * (i % 4)) & 32'hff, pq[i]);
        if (w0[27] && ctl[3]) exp_irqs = exp_irqs + 1;
        i_ahb_mem_model.mem[256 + 2 * sel] = w0;
        sel = w0[26] ? 0 : sel + 1;
      end else
        check(i_ahb_mem_model.mem[256 + 2 * sel], w0);
      if (rm) check(rq.size(), n);
      for (i = 0; rm && i < n; i = i + 1) check(rq[i], pq[i]);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, nc_valid, nc_eop, nc_eep, hdr_crc_bad, dat_crc_bad} = 8'h00;
    {slow, nc_data, paddr, pwdata} = 73'h0;
    err_addr = 32'hfffffffc;
    {fails, total_checks, irqs, exp_irqs, sel, ctl} = 192'h0;
    presetn = 1'b0;
    k = $urandom(32'hf8c1);
    for (k = 0; k < 1024; k = k + 1) i_ahb_mem_model.mem[k] = 32'h0;
    for (k = 0; k < 4; k = k + 1) begin
      i_ahb_mem_model.mem[256 + 2 * k] = {4'h0, k != 1, k == 2, 1'b1, 25'h0};
      i_ahb_mem_model.mem[257 + 2 * k] = 32'h800 + 64 * k;
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 5; k = k + 1) begin
      apb(1'b0, 4 * k, 32'h0);
      check({er, rd}, k == 4 ? 33'h100000000 : k == 1 ? 33'h400 : k == 2 ? 33'hfe : 33'h0);
    end
    apb(1'b1, `OFS_MAXLEN, 32'h8);
    apb(1'b1, `OFS_NODEADDR, 32'h22);
    apb(1'b1, `OFS_DESCTAB, 32'h400);
    setc(32'h0a);
    pkt(5, 8'h22, 8'h10, 8'h20, 0, 0, 0);
    setc(32'h0b);
    pkt(5, 8'h22, 8'h10, 8'h20, 0, 0, 0);
    apb(1'b0, `OFS_CTRL, 0);
    check(rd[9:8], 2'b01);
    apb(1'b1, `OFS_CTRL, 32'h10b);
    apb(1'b0, `OFS_CTRL, 0);
    check(rd[8], 0);
    setc(32'h4b);
    check({link_halt, link_state_code}, {1'b1, `LINK_ERR_RESET});
    setc(32'h0b);
    pkt(10, 8'h22, 8'h10, 8'h20, 1, 0, 0);
    pkt(4, 8'h33, 8'h10, 8'h20, 0, 0, 0);
    pkt(1, 8'h22, 8'h10, 8'h20, 0, 0, 0);
    slow <= 1'b1;
    pkt(6, 8'h22, 8'h01, 8'h00, 0, 1, 1);
    apb(1'b0, `OFS_DESCTAB, 0);
    check(rd, 32'h400);
    pkt(6, 8'h22, 8'h01, 8'h00, 0, 0, 1);
    i_ahb_mem_model.mem[256 + 2 * sel][25] = 1'b0;
    pkt(5, 8'h22, 8'h10, 8'h20, 0, 0, 0);
    apb(1'b0, `OFS_CTRL, 0);
    check(rd[1], 0);
    i_ahb_mem_model.mem[256 + 2 * sel][25] = 1'b1;
    setc(32'h0d);
    fork
      pkt(5, 8'h22, 8'h10, 8'h20, 0, 0, 0);
      begin
        repeat (100) @(posedge pclk);
        setc(32'h0f);
      end
    join
    setc(32'h1b);
    pkt(5, 8'h22, 8'h01, 8'h4c, 0, 0, 0);
    setc(32'h2b);
    pkt(3, 8'h55, 8'h10, 8'h20, 0, 0, 0);
    setc(32'h3b);
    pkt(4, 8'h55, 8'h01, 8'h40, 0, 0, 0);
    setc(32'h0b);
    err_addr <= 32'h800 + 64 * sel;
    sendp(6, 8'h22, 8'h10, 8'h20, 0);
    repeat (20) @(posedge pclk);
    check(link_halt, 1);
    apb(1'b0, `OFS_CTRL, 0);
    check({rd[6], rd[0]}, 2'b10);
    check(irqs, exp_irqs);
    final_report;
  end
endmodule
